// >>> rtl/edge_detector.sv
// Purpose: Synchronises one pin and flags the edge chosen by a two-bit field.
// Assumes: The pin is asynchronous to clock.
// Notes:   The pulse follows the pin by three clock edges.
`timescale 1ns/100ps
`default_nettype none
module edge_detector (
    input  wire logic       clock,  // System clock.
    input  wire logic       rst,    // Asynchronous reset, active high.
    input  wire logic       pin,    // Raw pin level.
    input  wire logic [1:0] mode,   // Edge selection field.
    output logic            level,  // Synchronised pin level.
    output logic            hit     // One-cycle pulse on a selected edge.
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= edge_sel_pkg::edge_hit(mode, prev, sync);
        end
    end

    assign level = sync;
endmodule : edge_detector
`default_nettype wire

// >>> rtl/edge_sel_pkg.sv
// Purpose: Shared constants and types for the timer input edge selection block.
// Assumes: One 250 MHz clock, byte-wide registers on a plain strobe port.
// Notes:   Edge codes are shared by the capture and event/trigger fields.
package edge_sel_pkg;
    localparam int unsigned ADDR_W = 28;
    localparam logic [27:0] CAPTURE_EDGE_CONTROL_ADDR       = 28'h00FFF50;
    localparam logic [27:0] EVENT_TRIGGER_EDGE_CONTROL_ADDR = 28'hFFFFF54;
    localparam logic [27:0] STATUS_ADDR                     = 28'h00FFF58;
    localparam logic [27:0] CONTROL_ADDR                    = 28'h00FFF5C;
    localparam logic [7:0]  CAPTURE_EDGE_RESET              = 8'h00;
    localparam logic [7:0]  EVENT_TRIGGER_RESET             = 8'h00;
    localparam logic [7:0]  EVENT_TRIGGER_MASK              = 8'h0F;
    localparam int unsigned EVENT_FIELD_LSB                 = 2;
    localparam int unsigned TRIGGER_FIELD_LSB               = 0;
    localparam int unsigned NUM_CAPTURE                     = 4;

    typedef enum logic [1:0] {
        EDGE_NONE    = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_BOTH    = 2'h3
    } edge_mode_e;

    typedef enum logic [1:0] {
        BIT_OP_BYTE  = 2'h0,
        BIT_OP_SET   = 2'h1,
        BIT_OP_CLEAR = 2'h2
    } bit_op_e;

    typedef struct packed {
        logic [27:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        bit_op_e     op;
        logic [2:0]  bit_idx;
    } reg_req_s;

    // Decodes a two-bit edge field against the previous and present pin levels.
    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        edge_hit = ((mode == EDGE_RISING || mode == EDGE_BOTH) && !prev && cur) ||
                   ((mode == EDGE_FALLING || mode == EDGE_BOTH) && prev && !cur);
    endfunction : edge_hit
endpackage : edge_sel_pkg

// >>> rtl/timer_input_edge_select.sv
// Purpose: Edge selection for the capture, event count and external trigger inputs.
// Assumes: Software follows the count-enable sequence when changing capture fields.
// Notes:   Counter, capture registers and mode logic sit outside this block.
// Function
// (R1) Second capture field: none, rise, fall, both.
// (R2) First capture field uses same four-way coding.
// (R3) Event/trigger register: 8 bits, upper four zero.
// (R4) Event/trigger register selects edges of pin a.
// (R5) Event/trigger register supports byte and bit access.
// (R6) Reset clears event/trigger register to zero.
// (R7) Software changes capture fields only while stopped.
`timescale 1ns/100ps
`default_nettype none
module timer_input_edge_select #(
    parameter int unsigned NUM_CAP = edge_sel_pkg::NUM_CAPTURE
) (
    input  wire logic                        clock,           // System clock, 250 MHz.
    input  wire logic                        rst,             // Asynchronous reset, active high.
    input  wire edge_sel_pkg::reg_req_s      req,             // Register request.
    output logic [7:0]                       rdata,           // Read data, one cycle after read strobe.
    input  wire logic [NUM_CAP-1:0]          cap_pins,        // Capture pins; bit 0 is pin a, bit 1 pin b.
    input  wire logic                        count_enable_bit, // Counter running flag.
    input  wire logic                        event_mode,      // Event count mode is selected.
    input  wire logic                        trigger_mode,    // External trigger mode is selected.
    output logic [NUM_CAP-1:0]               capture_pulse,   // Capture trigger per input.
    output logic                             event_pulse,     // Valid event count edge on pin a.
    output logic                             trigger_pulse    // Valid external trigger edge on pin a.
);
    logic [7:0]         capture_edge_control;
    logic [7:0]         event_trigger_edge_control;
    logic [7:0]         next_event_trigger;
    logic [7:0]         next_capture;
    logic [NUM_CAP-1:0] cap_level;
    logic [NUM_CAP-1:0] cap_hit;
    logic               ev_hit;
    logic               trg_hit;
    logic               late_write;
    logic               wr_cap;
    logic               wr_evt;

    assign wr_cap = req.wr && req.addr == edge_sel_pkg::CAPTURE_EDGE_CONTROL_ADDR;
    assign wr_evt = req.wr && req.addr == edge_sel_pkg::EVENT_TRIGGER_EDGE_CONTROL_ADDR;

    // Byte writes replace the value; bit writes set or clear one bit.
    function automatic logic [7:0] apply_write(input logic [7:0] cur, input edge_sel_pkg::reg_req_s r);
        unique case (r.op)
            edge_sel_pkg::BIT_OP_SET:   apply_write = cur | (8'h01 << r.bit_idx);
            edge_sel_pkg::BIT_OP_CLEAR: apply_write = cur & ~(8'h01 << r.bit_idx);
            default:                    apply_write = r.wdata;
        endcase
    endfunction : apply_write

    always_comb begin
        next_capture = apply_write(capture_edge_control, req);
        next_event_trigger = apply_write(event_trigger_edge_control, req) & edge_sel_pkg::EVENT_TRIGGER_MASK; // R3 R5
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_edge_control <= edge_sel_pkg::CAPTURE_EDGE_RESET;
        end else if (wr_cap) begin
            capture_edge_control <= next_capture;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_trigger_edge_control <= edge_sel_pkg::EVENT_TRIGGER_RESET; // R6
        end else if (wr_evt) begin
            event_trigger_edge_control <= next_event_trigger; // R5
        end
    end

    // A capture field written while counting is flagged so software can see the misuse.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            late_write <= 1'b0;
        end else if (wr_cap && count_enable_bit) begin
            late_write <= 1'b1; // R7
        end else if (req.wr && req.addr == edge_sel_pkg::STATUS_ADDR) begin
            late_write <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                edge_sel_pkg::CAPTURE_EDGE_CONTROL_ADDR:       rdata <= capture_edge_control;
                edge_sel_pkg::EVENT_TRIGGER_EDGE_CONTROL_ADDR: rdata <= event_trigger_edge_control; // R3
                edge_sel_pkg::STATUS_ADDR:                     rdata <= {6'h00, late_write, count_enable_bit};
                default:                                       rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CAP; i++) begin : g_cap
            edge_detector u_det (
                .clock (clock),
                .rst   (rst),
                .pin   (cap_pins[i]),
                .mode  (capture_edge_control[2*i +: 2]), // R1 R2
                .level (cap_level[i]),
                .hit   (cap_hit[i])
            );
        end
    endgenerate

    // Event and trigger share pin a's synchronised level; their own fields pick the edge.
    logic pin_a_prev;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_a_prev <= 1'b0;
        end else begin
            pin_a_prev <= cap_level[0];
        end
    end

    assign ev_hit  = edge_sel_pkg::edge_hit(event_trigger_edge_control[edge_sel_pkg::EVENT_FIELD_LSB +: 2],
                                            pin_a_prev, cap_level[0]); // R4
    assign trg_hit = edge_sel_pkg::edge_hit(event_trigger_edge_control[edge_sel_pkg::TRIGGER_FIELD_LSB +: 2],
                                            pin_a_prev, cap_level[0]); // R4

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_pulse <= '0;
            event_pulse   <= 1'b0;
            trigger_pulse <= 1'b0;
        end else begin
            capture_pulse <= cap_hit & {NUM_CAP{count_enable_bit}};
            event_pulse   <= ev_hit && event_mode && count_enable_bit;
            trigger_pulse <= trg_hit && trigger_mode && count_enable_bit;
        end
    end
endmodule : timer_input_edge_select
`default_nettype wire

// >>> tb/edge_sel_checker_asserts.sv
// Purpose: Port checks for the timer input edge selection block.
// Assumes: Pins stay low through reset.
// Notes:   Five quiet cycles are taken to empty the pulse pipeline.
`timescale 1ns/100ps
`default_nettype none
module edge_sel_checker #(
    parameter int unsigned NUM_CAP = 4
) (
    input wire logic                   clock,            // Clock.
    input wire logic                   rst,              // Reset.
    input wire edge_sel_pkg::reg_req_s req,              // Request.
    input wire logic [7:0]             rdata,            // Read data.
    input wire logic [NUM_CAP-1:0]     cap_pins,         // Pins.
    input wire logic                   count_enable_bit, // Running.
    input wire logic                   event_mode,       // Event mode.
    input wire logic                   trigger_mode,     // Trigger mode.
    input wire logic [NUM_CAP-1:0]     capture_pulse,    // Captures.
    input wire logic                   event_pulse,      // Event.
    input wire logic                   trigger_pulse     // Trigger.
);
    localparam logic [27:0] CAP = edge_sel_pkg::CAPTURE_EDGE_CONTROL_ADDR;
    localparam logic [27:0] EVT = edge_sel_pkg::EVENT_TRIGGER_EDGE_CONTROL_ADDR;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_wr_rd(a);
        req.wr && req.op == edge_sel_pkg::BIT_OP_BYTE && req.addr == a ##1 req.rd && req.addr == a;
    endsequence
    a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("read data without read");
    a_upper_zero: assert property ($past(req.rd) && $past(req.addr) == EVT |-> rdata[7:4] == 4'h0)
        else $error("upper bits not zero");
    a_evt_readback: assert property (s_wr_rd(EVT) |=> rdata == ($past(req.wdata, 2) & 8'h0F))
        else $error("event register readback wrong");
    a_cap_readback: assert property (s_wr_rd(CAP) |=> rdata == $past(req.wdata, 2))
        else $error("capture register readback wrong");
    a_stop_quiet: assert property ((!count_enable_bit)[*5] |-> capture_pulse == '0)
        else $error("capture while stopped");
    a_evt_gate: assert property ((!event_mode)[*5] |-> !event_pulse) else $error("event outside mode");
    a_trig_gate: assert property ((!trigger_mode)[*5] |-> !trigger_pulse) else $error("trigger outside mode");
    a_pins_quiet: assert property ($stable(cap_pins)[*5] |-> capture_pulse == '0 && !event_pulse)
        else $error("pulse without pin edge");
endmodule : edge_sel_checker
bind timer_input_edge_select edge_sel_checker #(.NUM_CAP(NUM_CAP)) u_chk (.clock(clock), .rst(rst), .req(req),
    .rdata(rdata), .cap_pins(cap_pins), .count_enable_bit(count_enable_bit), .event_mode(event_mode),
    .trigger_mode(trigger_mode), .capture_pulse(capture_pulse), .event_pulse(event_pulse),
    .trigger_pulse(trigger_pulse));
`default_nettype wire

// >>> tb/timer_input_edge_select_tb.sv
// Purpose: Self-checking bench for the timer input edge selection block.
// Assumes: Every write is read straight back, so strobes never overlap.
// Notes:   Each row sets one field, then counts pulses on a rise and a fall.
`timescale 1ns/100ps
`default_nettype none
module timer_input_edge_select_tb;
    localparam logic [27:0] CAP = edge_sel_pkg::CAPTURE_EDGE_CONTROL_ADDR;
    localparam logic [27:0] EVT = edge_sel_pkg::EVENT_TRIGGER_EDGE_CONTROL_ADDR;
    logic                   clock = 1'b0;
    logic                   rst = 1'b1;
    edge_sel_pkg::reg_req_s req = '0;
    logic [7:0]             rdata;
    logic [3:0]             cap_pins = 4'h0;
    logic                   count_enable_bit = 1'b0;
    logic                   event_mode = 1'b0;
    logic                   trigger_mode = 1'b0;
    logic [3:0]             capture_pulse;
    logic                   event_pulse;
    logic                   trigger_pulse;
    logic [2:0]             sel;
    logic [7:0]             npulse;
    int                     fails = 0;
    int                     n_compared = 0;
    wire logic [5:0]        seen = {trigger_pulse, event_pulse, capture_pulse};
    // One row per field code: the output watched, the byte written and the pulses expected.
    typedef struct packed {
        logic [2:0] sel;    // 0 to 3 capture input, 4 event count, 5 external trigger.
        logic [7:0] data;   // Byte written to the register that holds the field.
        logic [1:0] pulses; // Bit 0 a pulse on the rise, bit 1 a pulse on the fall.
    } row_s;
    localparam row_s ROWS [24] = '{
        '{3'h0, 8'h00, 2'h0}, '{3'h0, 8'h01, 2'h1}, '{3'h0, 8'h02, 2'h2}, '{3'h0, 8'h03, 2'h3},
        '{3'h1, 8'h00, 2'h0}, '{3'h1, 8'h04, 2'h1}, '{3'h1, 8'h08, 2'h2}, '{3'h1, 8'h0C, 2'h3},
        '{3'h2, 8'h00, 2'h0}, '{3'h2, 8'h10, 2'h1}, '{3'h2, 8'h20, 2'h2}, '{3'h2, 8'h30, 2'h3},
        '{3'h3, 8'h00, 2'h0}, '{3'h3, 8'h40, 2'h1}, '{3'h3, 8'h80, 2'h2}, '{3'h3, 8'hC0, 2'h3},
        '{3'h4, 8'h00, 2'h0}, '{3'h4, 8'h04, 2'h1}, '{3'h4, 8'h08, 2'h2}, '{3'h4, 8'h0C, 2'h3},
        '{3'h5, 8'h00, 2'h0}, '{3'h5, 8'h01, 2'h1}, '{3'h5, 8'h02, 2'h2}, '{3'h5, 8'h03, 2'h3}
    };
    always #2 clock = ~clock;
    timer_input_edge_select #(.NUM_CAP(4)) dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
        .cap_pins(cap_pins), .count_enable_bit(count_enable_bit), .event_mode(event_mode),
        .trigger_mode(trigger_mode), .capture_pulse(capture_pulse), .event_pulse(event_pulse),
        .trigger_pulse(trigger_pulse));
    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [27:0] a, input logic [7:0] exp);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, op: edge_sel_pkg::BIT_OP_BYTE, bit_idx: 3'h0};
        @(posedge clock);
        req <= '0;
        #1;
        chk(rdata, exp);
        // The spare cycle lets the next request start on a rising edge.
        @(posedge clock);
    endtask : rd
    task wrd(input logic [27:0] a, input logic [7:0] d, input edge_sel_pkg::bit_op_e op, input logic [2:0] b,
             input logic [7:0] exp);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, op: op, bit_idx: b};
        @(posedge clock);
        rd(a, exp);
    endtask : wrd
    // Ten cycles cover the synchroniser and output register with margin.
    task pin(input logic v);
        npulse = 8'h00;
        cap_pins[sel[2] ? 2'h0 : sel[1:0]] <= v;
        repeat (10) begin
            #1;
            if (seen[sel] === 1'b1) npulse++;
            @(posedge clock);
        end
    endtask : pin
    initial begin
        #20000;
        fails++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(EVT, 8'h00);
        rd(CAP, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 24; i++) begin
            sel = ROWS[i].sel;
            event_mode <= (sel == 3'h4);
            trigger_mode <= (sel == 3'h5);
            count_enable_bit <= 1'b0;
            wrd(sel[2] ? EVT : CAP, ROWS[i].data, edge_sel_pkg::BIT_OP_BYTE, 3'h0, ROWS[i].data);
            count_enable_bit <= 1'b1;
            pin(1'b1);
            chk(npulse, {7'h00, ROWS[i].pulses[0]});
            pin(1'b0);
            chk(npulse, {7'h00, ROWS[i].pulses[1]});
        end
        $display("edge rows done");
        wrd(EVT, 8'hFF, edge_sel_pkg::BIT_OP_BYTE, 3'h0, 8'h0F);
        wrd(EVT, 8'h00, edge_sel_pkg::BIT_OP_CLEAR, 3'h1, 8'h0D);
        wrd(EVT, 8'h00, edge_sel_pkg::BIT_OP_SET, 3'h6, 8'h0D);
        wrd(EVT, 8'h00, edge_sel_pkg::BIT_OP_SET, 3'h1, 8'h0F);
        rd(28'h0000000, 8'h00);
        $display("register access done");
        count_enable_bit <= 1'b0;
        sel = 3'h0;
        wrd(CAP, 8'h03, edge_sel_pkg::BIT_OP_BYTE, 3'h0, 8'h03);
        pin(1'b1);
        chk(npulse, 8'h00);
        pin(1'b0);
        chk(npulse, 8'h00);
        $display("stopped capture done");
        // Deliberate misuse: a capture write while counting must raise the sticky flag.
        count_enable_bit <= 1'b1;
        wrd(CAP, 8'h55, edge_sel_pkg::BIT_OP_BYTE, 3'h0, 8'h55);
        rd(edge_sel_pkg::STATUS_ADDR, 8'h03);
        wrd(edge_sel_pkg::STATUS_ADDR, 8'h00, edge_sel_pkg::BIT_OP_BYTE, 3'h0, 8'h01);
        $display("late capture write done");
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(EVT, 8'h00);
        rd(CAP, 8'h00);
        $display("second reset done");
        close_out();
    end
endmodule : timer_input_edge_select_tb
`default_nettype wire
